// ### rtl/iodr_port_regs.sv
// direction and output value registers for one 32-pin i/o group
//
// Functional notes
// - direction bit 0 input, 1 output
// - clear write of one clears direction bit
// - zero bits in clear/set/toggle change nothing
// - set write of one sets direction bit
// - toggle write of one inverts direction bit
// - all direction views share one state
// - each masked change takes one write
// - offsets 0x00/0x04/0x08/0x0C, 32 bits, reset zero
// - output value bits 31:0 read and write
// - output bit sets drive level or pull
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`default_nettype none

`include "iodr_consts.svh"

module iodr_port_regs
  import iodr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire iodr_req_s bus_req,
  output logic [31:0] bus_rdata,
  // write protection
  input wire logic write_protection_lock,
  output logic write_refused,
  // pin configuration
  input wire logic [31:0] pull_resistor_enable,
  // pad controls
  output iodr_pad_s pad
);

  // ==========================================================
  // state
  logic [31:0] dir_q;
  logic [31:0] dir_d;
  logic [31:0] out_q;
  logic [31:0] out_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic refused_q;
  logic refused_d;

  // ==========================================================
  // address decode
  wire logic hit_dir;
  wire logic hit_clr;
  wire logic hit_set;
  wire logic hit_tgl;
  wire logic hit_out;
  wire logic hit_dir_view;
  wire logic hit_any;

  assign hit_dir = bus_req.addr == `IODR_OFS_DIR;
  assign hit_clr = bus_req.addr == `IODR_OFS_DIR_CLR;
  assign hit_set = bus_req.addr == `IODR_OFS_DIR_SET;
  assign hit_tgl = bus_req.addr == `IODR_OFS_DIR_TGL;
  assign hit_out = bus_req.addr == `IODR_OFS_OUT;
  assign hit_dir_view = hit_dir || hit_clr || hit_set || hit_tgl;
  assign hit_any = hit_dir_view || hit_out;

  // ==========================================================
  // write qualification
  // the lock gates the strobe itself, so no path can slip a write past it
  wire logic wr_ok;
  wire logic wr_blocked;

  assign wr_ok = bus_req.wr && !write_protection_lock;
  assign wr_blocked = bus_req.wr && write_protection_lock && hit_any;

  // ==========================================================
  // direction next value
  // one write applies the mask in hardware, no read-modify-write needed
  wire logic [31:0] dir_cleared;
  wire logic [31:0] dir_setted;
  wire logic [31:0] dir_toggled;
  wire logic [31:0] dir_written;

  assign dir_cleared = dir_q & ~bus_req.wdata;
  assign dir_setted = dir_q | bus_req.wdata;
  assign dir_toggled = dir_q ^ bus_req.wdata;
  assign dir_written = hit_dir ? bus_req.wdata :
                       hit_clr ? dir_cleared :
                       hit_set ? dir_setted :
                       hit_tgl ? dir_toggled : dir_q;
  assign dir_d = wr_ok ? dir_written : dir_q;

  // ==========================================================
  // output value next value
  assign out_d = (wr_ok && hit_out) ? bus_req.wdata : out_q;

  // ==========================================================
  // read data
  // every direction view returns the single shared state
  wire logic [31:0] rd_mux;

  assign rd_mux = hit_dir_view ? dir_q :
                  hit_out ? out_q : `IODR_RD_IDLE;
  assign rdata_d = bus_req.rd ? rd_mux : `IODR_RD_IDLE;

  // ==========================================================
  // refused write flag, a one-cycle pulse
  assign refused_d = wr_blocked;

  // ==========================================================
  // registers
  always_ff @(posedge clk) begin
    if (rst) begin
      dir_q <= `IODR_RST_DIR;
      out_q <= `IODR_RST_OUT;
    end else begin
      dir_q <= dir_d;
      out_q <= out_d;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_q <= `IODR_RD_IDLE;
      refused_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      refused_q <= refused_d;
    end
  end

  assign bus_rdata = rdata_q;
  assign write_refused = refused_q;

  // ==========================================================
  // per-pin pad controls
  // pad controls lag the registers by one cycle so they leave from flops
  for (genvar i = 0; i < `IODR_PINS; i++) begin : g_pin
    iodr_pin_cell u_cell (
      .clk(clk),
      .rst(rst),
      .dir(dir_q[i]),
      .out_val(out_q[i]),
      .pull_resistor_enable(pull_resistor_enable[i]),
      .oe_q(pad.oe[i]),
      .drive_q(pad.drive[i]),
      .pull_up_q(pad.pull_up[i]),
      .pull_down_q(pad.pull_down[i])
    );
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_clr_write;
    bus_req.wr && hit_clr && !write_protection_lock;
  endsequence

  sequence s_set_write;
    bus_req.wr && hit_set && !write_protection_lock;
  endsequence

  sequence s_tgl_write;
    bus_req.wr && hit_tgl && !write_protection_lock;
  endsequence

  sequence s_view_read;
    bus_req.rd && hit_dir_view && !bus_req.wr;
  endsequence

  a_dir_clear_mask: assert property (
    s_clr_write |=> dir_q == ($past(dir_q) & ~$past(bus_req.wdata)))
    else $error("clear write did not clear masked direction bits");

  a_dir_set_mask: assert property (
    s_set_write |=> dir_q == ($past(dir_q) | $past(bus_req.wdata)))
    else $error("set write did not set masked direction bits");

  a_dir_toggle_mask: assert property (
    s_tgl_write |=> dir_q == ($past(dir_q) ^ $past(bus_req.wdata)))
    else $error("toggle write did not invert masked direction bits");

  a_zero_bits_keep: assert property (
    (s_clr_write or s_set_write or s_tgl_write)
      |=> ((dir_q ^ $past(dir_q)) & ~$past(bus_req.wdata)) == 32'h00000000)
    else $error("zero mask bit changed a direction bit");

  // the bench leaves one idle cycle between a write and the read behind it
  a_view_shared: assert property (
    (s_set_write ##2 s_view_read) |=> bus_rdata == $past(dir_q))
    else $error("direction view does not show shared state");

  a_one_write_step: assert property (
    s_set_write |=> (dir_q & $past(bus_req.wdata)) == $past(bus_req.wdata))
    else $error("masked set needed more than one write");

  a_out_readback: assert property (
    (bus_req.wr && hit_out && !write_protection_lock)
      ##2 (bus_req.rd && hit_out && !bus_req.wr)
      |=> bus_rdata == $past(bus_req.wdata, 3))
    else $error("output value did not read back");

  a_lock_holds: assert property (
    (bus_req.wr && write_protection_lock) |=> $stable(dir_q) && $stable(out_q)
      && write_refused == $past(hit_any))
    else $error("locked write changed register state");

  a_reset_zero: assert property (@(posedge clk) disable iff (1'b0)
    rst |=> dir_q == 32'h00000000 && out_q == 32'h00000000 && !write_refused)
    else $error("registers not zero after reset");

  a_pad_follows: assert property (
    (!bus_req.wr) [*2] |=> pad.oe == $past(dir_q))
    else $error("pad enables do not follow direction");

  a_idle_rdata: assert property (
    !bus_req.rd |=> bus_rdata == 32'h00000000)
    else $error("read data not idle outside a read");

  // ==========================================================
  // further checks on writes, reads and pads
  sequence s_dir_write;
    bus_req.wr && hit_dir && !write_protection_lock;
  endsequence

  sequence s_out_write;
    bus_req.wr && hit_out && !write_protection_lock;
  endsequence

  sequence s_blocked_write;
    bus_req.wr && write_protection_lock && hit_any;
  endsequence

  sequence s_unmapped_write;
    bus_req.wr && !hit_any;
  endsequence

  // expected pull state, computed apart from the pin cells
  wire logic [31:0] pull_up_exp;
  wire logic [31:0] pull_down_exp;

  assign pull_up_exp = ~dir_q & pull_resistor_enable & out_q;
  assign pull_down_exp = ~dir_q & pull_resistor_enable & ~out_q;

  a_dir_plain_write: assert property (
    s_dir_write
      |=> dir_q == $past(bus_req.wdata))
    else $error("direction write did not replace direction state");

  a_clear_only_clears: assert property (
    s_clr_write
      |=> (dir_q & ~$past(dir_q)) == 32'h00000000)
    else $error("clear write raised a direction bit");

  a_set_only_sets: assert property (
    s_set_write
      |=> ($past(dir_q) & ~dir_q) == 32'h00000000)
    else $error("set write dropped a direction bit");

  a_tgl_flips_ones: assert property (
    s_tgl_write
      |=> (dir_q ^ $past(dir_q)) == $past(bus_req.wdata))
    else $error("toggle write flipped the wrong bits");

  a_out_write: assert property (
    s_out_write
      |=> out_q == $past(bus_req.wdata))
    else $error("output value write did not land");

  a_dir_keeps_out: assert property (
    (s_dir_write or s_clr_write or s_set_write or s_tgl_write)
      |=> $stable(out_q))
    else $error("direction write changed output value");

  a_out_keeps_dir: assert property (
    s_out_write
      |=> $stable(dir_q))
    else $error("output value write changed direction");

  a_idle_holds: assert property (
    !bus_req.wr
      |=> $stable(dir_q) && $stable(out_q))
    else $error("register state changed without a write");

  // a change always traces back to one accepted write or to reset
  a_dir_cause: assert property (
    $changed(dir_q)
      |-> $past(wr_ok) || $past(rst))
    else $error("direction changed with no write behind it");

  a_out_cause: assert property (
    $changed(out_q)
      |-> $past(wr_ok) || $past(rst))
    else $error("output value changed with no write behind it");

  a_unmapped_wr: assert property (
    s_unmapped_write
      |=> $stable(dir_q) && $stable(out_q) && !write_refused)
    else $error("unmapped write touched register state");

  a_refuse_raised: assert property (
    s_blocked_write
      |=> write_refused)
    else $error("blocked write not flagged");

  a_refuse_cause: assert property (
    write_refused
      |-> $past(wr_blocked))
    else $error("refused flag without a blocked write");

  a_open_no_refuse: assert property (
    (bus_req.wr && !write_protection_lock)
      |=> !write_refused)
    else $error("write flagged refused while unlocked");

  a_read_dir_view: assert property (
    (bus_req.rd && hit_dir_view)
      |=> bus_rdata == $past(dir_q))
    else $error("direction view read returned wrong data");

  a_read_out: assert property (
    (bus_req.rd && hit_out)
      |=> bus_rdata == $past(out_q))
    else $error("output value read returned wrong data");

  a_read_unmapped: assert property (
    (bus_req.rd && !hit_any)
      |=> bus_rdata == 32'h00000000)
    else $error("unmapped read returned data");

  a_pad_drive: assert property (
    1'b1
      |=> pad.drive == $past(out_q))
    else $error("pad drive does not follow output value");

  a_pad_pull_up: assert property (
    1'b1
      |=> pad.pull_up == $past(pull_up_exp))
    else $error("pull-up select wrong");

  a_pad_pull_down: assert property (
    1'b1
      |=> pad.pull_down == $past(pull_down_exp))
    else $error("pull-down select wrong");

  // both pulls on one pin would fight each other
  a_pull_exclusive: assert property (
    (pad.pull_up & pad.pull_down) == 32'h00000000)
    else $error("pull-up and pull-down both on");

  a_out_pin_no_pull: assert property (
    (pad.oe & (pad.pull_up | pad.pull_down)) == 32'h00000000)
    else $error("pull active on an output pin");

  a_reset_outputs: assert property (@(posedge clk) disable iff (1'b0)
    rst
      |=> bus_rdata == 32'h00000000 && pad.oe == 32'h00000000
        && pad.drive == 32'h00000000)
    else $error("outputs not zero after reset");

endmodule : iodr_port_regs

`default_nettype wire

// ### shared/iodr_consts.svh
// offsets, reset values and sizes of the i/o direction and output registers
`ifndef IODR_CONSTS_SVH
`define IODR_CONSTS_SVH

// ==========================================================
// sizes
`define IODR_PINS 32
`define IODR_AW 8
`define IODR_DW 32

// ==========================================================
// register offsets (byte addresses)
`define IODR_OFS_DIR 8'h00
`define IODR_OFS_DIR_CLR 8'h04
`define IODR_OFS_DIR_SET 8'h08
`define IODR_OFS_DIR_TGL 8'h0C
`define IODR_OFS_OUT 8'h10

// ==========================================================
// reset and idle values
`define IODR_RST_DIR 32'h00000000
`define IODR_RST_OUT 32'h00000000
`define IODR_RD_IDLE 32'h00000000

`endif

// ### shared/iodr_pkg.sv
// types shared by the i/o direction and output register block
package iodr_pkg;

  // ==========================================================
  // register port request, one cycle per access
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } iodr_req_s;

  // ==========================================================
  // pad controls for the whole group, one bit per pin
  typedef struct packed {
    logic [31:0] oe;
    logic [31:0] drive;
    logic [31:0] pull_up;
    logic [31:0] pull_down;
  } iodr_pad_s;

endpackage : iodr_pkg

// ### rtl/iodr_pin_cell.sv
// per-pin pad control flops for one i/o pin
`timescale 1ns/1ps
`default_nettype none

module iodr_pin_cell (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register state for this pin
  input wire logic dir,
  input wire logic out_val,
  input wire logic pull_resistor_enable,
  // pad controls
  output logic oe_q,
  output logic drive_q,
  output logic pull_up_q,
  output logic pull_down_q
);

  // ==========================================================
  // pull select
  wire logic pull_on;
  assign pull_on = !dir && pull_resistor_enable;

  always_ff @(posedge clk) begin
    if (rst) begin
      oe_q <= 1'b0;
      drive_q <= 1'b0;
      pull_up_q <= 1'b0;
      pull_down_q <= 1'b0;
    end else begin
      oe_q <= dir;
      drive_q <= out_val;
      pull_up_q <= pull_on && out_val;
      pull_down_q <= pull_on && !out_val;
    end
  end

  // ==========================================================
  // checks
  a_cell_oe_dir: assert property (@(posedge clk) disable iff (rst)
    ##1 oe_q == $past(dir))
    else $error("pad enable does not follow direction");

  a_cell_pull_sel: assert property (@(posedge clk) disable iff (rst)
    (!dir && pull_resistor_enable) |=> (pull_up_q == $past(out_val))
      && (pull_down_q == !$past(out_val)))
    else $error("pull direction does not follow output bit");

  a_cell_no_pull: assert property (@(posedge clk) disable iff (rst)
    (dir || !pull_resistor_enable) |=> !pull_up_q && !pull_down_q)
    else $error("pull active on output or unpulled pin");

endmodule : iodr_pin_cell

`default_nettype wire

// ### tb/tb_iodr_port_regs.sv
// self-checking testbench for the direction and output value register block
`timescale 1ns/1ps
`default_nettype none

`include "iodr_consts.svh"

module tb_iodr_port_regs
  import iodr_pkg::*;
;
  // ==========================================================
  // clock, reset and design hookup
  logic clk = 1'h0;
  logic rst = 1'h1;
  iodr_req_s bus_req = '0;
  logic [31:0] bus_rdata;
  logic write_protection_lock = 1'h0;
  logic write_refused;
  logic [31:0] pull_resistor_enable = 32'h0;
  iodr_pad_s pad;
  int n_errors = 0;
  int total_checks = 0;
  logic [31:0] rng = 32'h11;
  logic [31:0] dir_m = 32'h0;
  logic [31:0] out_m = 32'h0;
  logic [7:0] tab [6] = '{`IODR_OFS_DIR, `IODR_OFS_DIR_CLR, `IODR_OFS_DIR_SET,
                          `IODR_OFS_DIR_TGL, `IODR_OFS_OUT, 8'h14};

  always #2 clk = ~clk;

  iodr_port_regs iodr_port_regs_inst (
    .clk(clk),
    .rst(rst),
    .bus_req(bus_req),
    .bus_rdata(bus_rdata),
    .write_protection_lock(write_protection_lock),
    .write_refused(write_refused),
    .pull_resistor_enable(pull_resistor_enable),
    .pad(pad)
  );

  // ==========================================================
  // helpers and reference model
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : xs

  function automatic logic mapped(input logic [7:0] a);
    return a inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
  endfunction : mapped

  // all four direction views read back the one shared state
  function automatic logic [31:0] exp_rd(input logic [7:0] a);
    if (a == 8'h10) return out_m;
    return (a <= 8'h0C && a[1:0] == 2'h0) ? dir_m : 32'h0;
  endfunction : exp_rd

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    if (n_errors == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // ==========================================================
  // bus cycles
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic lk);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
    write_protection_lock <= lk;
    @(posedge clk);
    bus_req.wr <= 1'h0;
    #1;
    check({31'h0, write_refused}, {31'h0, lk & mapped(a)});
    if (!lk) begin
      case (a)
        8'h00: dir_m = d;
        8'h04: dir_m = dir_m & ~d;
        8'h08: dir_m = dir_m | d;
        8'h0C: dir_m = dir_m ^ d;
        8'h10: out_m = d;
        default: ;
      endcase
    end
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: xs(), wr: 1'h0, rd: 1'h1};
    @(posedge clk);
    bus_req.rd <= 1'h0;
    #1;
    check(bus_rdata, exp_rd(a));
  endtask : rd

  // pads follow register state one cycle after it settles
  task automatic pads();
    @(posedge clk);
    #1;
    check(pad.oe, dir_m);
    check(pad.drive, out_m);
    check(pad.pull_up, ~dir_m & pull_resistor_enable & out_m);
    check(pad.pull_down, ~dir_m & pull_resistor_enable & ~out_m);
  endtask : pads

  // ==========================================================
  // main sequence
  initial begin
    logic [31:0] r;
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    pads();
    foreach (tab[i]) rd(tab[i]);
    wr(8'h08, 32'hFFFF0000, 1'h0);
    rd(8'h0C);
    wr(8'h04, 32'h0F0F0000, 1'h0);
    rd(8'h00);
    wr(8'h0C, 32'h0000FFFF, 1'h0);
    rd(8'h04);
    wr(8'h10, 32'hA5A5A5A5, 1'h0);
    @(posedge clk);
    pull_resistor_enable <= 32'hFFFFFFFF;
    pads();
    wr(8'h10, 32'h5A5A5A5A, 1'h1);
    rd(8'h10);
    wr(8'h08, 32'hFFFFFFFF, 1'h1);
    rd(8'h08);
    wr(8'h14, 32'hFFFFFFFF, 1'h0);
    rd(8'h14);
    // random traffic over every offset, lock asserted now and then
    for (int n = 0; n < 60; n++) begin
      r = xs();
      @(posedge clk);
      pull_resistor_enable <= xs();
      wr(tab[r[7:0] % 6], xs(), r[9:8] == 2'h0);
      r = xs();
      rd(tab[r[7:0] % 6]);
      pads();
    end
    // mid-run reset returns every view to zero
    @(posedge clk);
    rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    dir_m = 32'h0;
    out_m = 32'h0;
    foreach (tab[i]) rd(tab[i]);
    pads();
    tally_and_finish();
  end

  // ==========================================================
  // watchdog, well beyond the roughly 430 cycles the sequence needs
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    tally_and_finish();
  end

endmodule : tb_iodr_port_regs

`default_nettype wire
